// *** hw/prc_pkg.sv ***
// package: frame layout, register addresses and pin control types
package prc_pkg;
  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int FRAME_W = 16;
  localparam int MSB_POS = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 11;
  localparam int FIELD_W = 11;
  localparam int NCH = 8;
  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_OUT_SELECT = 4'h8;
  localparam logic [3:0] ADDR_POWER_DOWN_REFERENCE_CONTROL = 4'hB;
  localparam logic [3:0] ADDR_OUTPUT_DRIVE_TYPE_CONFIG = 4'hC;
  localparam logic [3:0] ADDR_PIN_TRISTATE_CONFIG = 4'hD;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int GLOBAL_POWER_DOWN_POS = 10;
  localparam int REF_ENABLE_POS = 9;
  localparam logic [10:0] FIELD_RESET = 11'h000;
  typedef enum logic [1:0] {PRC_IDLE = 2'b00, PRC_SHIFT = 2'b01} prc_state_t;
  typedef struct packed {
    logic [NCH-1:0] high_impedance;
    logic [NCH-1:0] open_drain;
    logic [NCH-1:0] push_pull;
  } prc_pin_mode_t;
endpackage

// *** hw/prc_regs.sv ***
// module: serial-written power, reference and pin drive registers
`timescale 1ns/1ps
module prc_regs
  import prc_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // serial frame
  input wire logic SCLK,
  input wire logic SYNC_N,
  input wire logic SDI,
  // per-channel role from the pin configuration logic
  input wire logic [NCH-1:0] DAC_CHANNEL,
  // power control
  output logic REF_POWER_UP,
  output logic ADC_POWER_DOWN,
  output logic [NCH-1:0] DAC_POWER_DOWN,
  // pin drive
  output prc_pin_mode_t PIN_MODE,
  // register state
  output logic [FIELD_W-1:0] POWER_DOWN_REFERENCE_CONTROL,
  output logic [FIELD_W-1:0] OUTPUT_DRIVE_TYPE_CONFIG,
  output logic [FIELD_W-1:0] PIN_TRISTATE_CONFIG
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ------------------------------------------------------------
  // frame capture
  // ------------------------------------------------------------
  // serial pins are taken as synchronous to MCLK; bit shifted on rising SCLK
  logic sclk_q;
  logic [FRAME_W-1:0] shift_q;
  logic [4:0] count_q;
  prc_state_t state_q;
  logic frame_done;
  assign frame_done = (state_q == PRC_SHIFT) && SYNC_N && (count_q == 5'h10);

  always_ff @(posedge MCLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      sclk_q <= 1'b0;
    else
      sclk_q <= SCLK;
  end

  always_ff @(posedge MCLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= PRC_IDLE;
      shift_q <= 16'h0000;
      count_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        PRC_IDLE:
        begin
          if (!SYNC_N)
          begin
            state_q <= PRC_SHIFT;
            count_q <= 5'h00;
          end
        end
        PRC_SHIFT:
        begin
          if (SYNC_N)
            state_q <= PRC_IDLE;
          else if (SCLK && !sclk_q && count_q != 5'h10)
          begin
            shift_q <= {shift_q[FRAME_W-2:0], SDI};
            count_q <= count_q + 5'h01;
          end
        end
        default: state_q <= PRC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // short frames are dropped whole, so a glitched frame never half-writes
  function automatic logic hit(input logic [FRAME_W-1:0] f, input logic [3:0] a);
    hit = !f[MSB_POS] && (f[ADDR_HI:ADDR_LO] == a);
  endfunction

  logic [FIELD_W-1:0] pdref_q;
  logic [FIELD_W-1:0] drive_q;
  logic [FIELD_W-1:0] ts_q;
  logic [NCH-1:0] outsel_q;

  always_ff @(posedge MCLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pdref_q <= FIELD_RESET;
      drive_q <= FIELD_RESET;
      ts_q <= FIELD_RESET;
      outsel_q <= FIELD_RESET[NCH-1:0];
    end
    else if (frame_done)
    begin
      if (hit(shift_q, ADDR_POWER_DOWN_REFERENCE_CONTROL))
        pdref_q <= shift_q[FIELD_W-1:0];
      if (hit(shift_q, ADDR_OUTPUT_DRIVE_TYPE_CONFIG))
        drive_q <= shift_q[FIELD_W-1:0];
      if (hit(shift_q, ADDR_PIN_TRISTATE_CONFIG))
        ts_q <= shift_q[FIELD_W-1:0];
      if (hit(shift_q, ADDR_OUT_SELECT))
        outsel_q <= shift_q[NCH-1:0];
    end
  end

  // ------------------------------------------------------------
  // power and pin control
  // ------------------------------------------------------------
  logic all_down;
  assign all_down = pdref_q[GLOBAL_POWER_DOWN_POS];
  assign ADC_POWER_DOWN = all_down;
  assign REF_POWER_UP = !all_down && pdref_q[REF_ENABLE_POS];
  // non-DAC channels ignore their power-down bit
  assign DAC_POWER_DOWN = all_down ? DAC_CHANNEL
                        : (pdref_q[NCH-1:0] & DAC_CHANNEL);
  // drive type only matters on output-selected pins; three-state overrides both
  assign PIN_MODE.high_impedance = ts_q[NCH-1:0];
  assign PIN_MODE.open_drain = outsel_q & drive_q[NCH-1:0] & ~ts_q[NCH-1:0];
  assign PIN_MODE.push_pull = outsel_q & ~drive_q[NCH-1:0] & ~ts_q[NCH-1:0];
  assign POWER_DOWN_REFERENCE_CONTROL = pdref_q;
  assign OUTPUT_DRIVE_TYPE_CONFIG = drive_q;
  assign PIN_TRISTATE_CONFIG = ts_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_pd_frame;
    frame_done && hit(shift_q, ADDR_POWER_DOWN_REFERENCE_CONTROL);
  endsequence

  a_pd_write: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    s_pd_frame |=> POWER_DOWN_REFERENCE_CONTROL == $past(shift_q[FIELD_W-1:0]))
    else $error("power register not written");
  a_drive_write: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    frame_done && hit(shift_q, ADDR_OUTPUT_DRIVE_TYPE_CONFIG)
    |=> OUTPUT_DRIVE_TYPE_CONFIG == $past(shift_q[FIELD_W-1:0]))
    else $error("drive register not written");
  a_ts_write: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    frame_done && hit(shift_q, ADDR_PIN_TRISTATE_CONFIG)
    |=> PIN_TRISTATE_CONFIG == $past(shift_q[FIELD_W-1:0]))
    else $error("three-state register not written");
  a_no_stray: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    !frame_done |=> $stable(pdref_q) && $stable(drive_q) && $stable(ts_q))
    else $error("register changed without frame");
  a_all_down: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    all_down |-> ADC_POWER_DOWN && !REF_POWER_UP && DAC_POWER_DOWN == DAC_CHANNEL)
    else $error("global power-down not applied");
  a_ref_follow: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    !all_down |-> REF_POWER_UP == POWER_DOWN_REFERENCE_CONTROL[REF_ENABLE_POS])
    else $error("reference state wrong");
  a_dac_only: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    (DAC_POWER_DOWN & ~DAC_CHANNEL) == 8'h00)
    else $error("non-DAC channel powered down");
  a_ts_excl: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    ((PIN_MODE.open_drain | PIN_MODE.push_pull) & PIN_TRISTATE_CONFIG[NCH-1:0]) == 8'h00)
    else $error("three-state pin still driven");

  // a bit is taken only on a sampled rising serial clock inside a frame
  sequence s_bit_taken;
    state_q == PRC_SHIFT && !SYNC_N && SCLK && !sclk_q && count_q != 5'h10;
  endsequence

  // frame closed before all sixteen bits arrived
  sequence s_short_end;
    state_q == PRC_SHIFT && SYNC_N && count_q != 5'h10;
  endsequence

  a_bit_shift: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    s_bit_taken |=> count_q == $past(count_q) + 5'h01 && shift_q[0] == $past(SDI))
    else $error("serial bit not taken");
  a_count_cap: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    count_q <= 5'h10)
    else $error("bit count beyond frame length");
  a_short_drop: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    s_short_end |=> $stable(pdref_q) && $stable(drive_q) && $stable(ts_q) && $stable(outsel_q))
    else $error("short frame changed a register");
  a_pin_excl: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    (PIN_MODE.open_drain & PIN_MODE.push_pull) == 8'h00)
    else $error("pin both open-drain and push-pull");
  a_drive_sel: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    (PIN_MODE.open_drain | PIN_MODE.push_pull) == (outsel_q & ~PIN_TRISTATE_CONFIG[NCH-1:0]))
    else $error("output-selected pin not driven");
  a_dac_follow: assert property (@(posedge MCLK) disable iff (!rst_n_q)
    !all_down |-> DAC_POWER_DOWN == (POWER_DOWN_REFERENCE_CONTROL[NCH-1:0] & DAC_CHANNEL))
    else $error("channel power-down wrong");
endmodule

// *** tb/prc_host.sv ***
// serial host model writing configuration frames
`timescale 1ns/1ps
module prc_host (
  // clock
  input wire logic MCLK,
  // serial frame
  output logic SCLK,
  output logic SYNC_N,
  output logic SDI
);
  initial
  begin
    SCLK = 1'b0;
    SYNC_N = 1'b1;
    SDI = 1'b0;
  end
  // msb first; clock stands low outside frames
  task automatic send(input logic [15:0] frame, input int nbits);
    begin
      @(posedge MCLK) #10 SYNC_N = 1'b0;
      for (int i = 15; i > 15 - nbits; i--)
      begin
        @(posedge MCLK) #10 SCLK = 1'b0;
        SDI = frame[i];
        @(posedge MCLK) #10 SCLK = 1'b1;
      end
      @(posedge MCLK) #10 SCLK = 1'b0;
      SYNC_N = 1'b1;
      // released line must not keep showing the last bit
      SDI = ~SDI;
      @(posedge MCLK);
    end
  endtask
endmodule

// *** tb/tb_prc_regs.sv ***
// testbench: serial writes to power, reference and pin drive registers
`timescale 1ns/1ps
module tb_prc_regs;
  import prc_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, sync_n, sdi, ref_up, adc_pd;
  logic [NCH-1:0] dac_ch = 8'h33;
  logic [NCH-1:0] dac_pd;
  prc_pin_mode_t pm;
  logic [FIELD_W-1:0] pd_r, od_r, ts_r;
  int error_cnt = 0;
  int samples_checked = 0;
  always #50 mclk = ~mclk;
  prc_host host_u (.MCLK(mclk), .SCLK(sclk), .SYNC_N(sync_n), .SDI(sdi));
  prc_regs dut_u (.MCLK(mclk), .NRST(nrst), .SCLK(sclk), .SYNC_N(sync_n), .SDI(sdi),
    .DAC_CHANNEL(dac_ch), .REF_POWER_UP(ref_up), .ADC_POWER_DOWN(adc_pd),
    .DAC_POWER_DOWN(dac_pd), .PIN_MODE(pm), .POWER_DOWN_REFERENCE_CONTROL(pd_r),
    .OUTPUT_DRIVE_TYPE_CONFIG(od_r), .PIN_TRISTATE_CONFIG(ts_r));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    begin
      samples_checked++;
      if (seen !== exp)
      begin
        error_cnt++;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic print_verdict;
    begin
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // update lands one edge after the frame end is seen
  task automatic wr(input logic [15:0] frame, input int nbits);
    begin
      host_u.send(frame, nbits);
      repeat (2) @(posedge mclk);
      #10;
    end
  endtask
  task automatic t_reset;
    begin
      chk(24'({ref_up, adc_pd, dac_pd}), 24'h000);
      chk(pm, 24'h000000);
    end
  endtask
  task automatic t_power;
    begin
      wr({1'b0, ADDR_POWER_DOWN_REFERENCE_CONTROL, 11'h20F}, 16);
      chk(24'(pd_r), 24'h20F);
      chk(24'({ref_up, adc_pd, dac_pd}), 24'h203);
      wr({1'b0, ADDR_POWER_DOWN_REFERENCE_CONTROL, 11'h6F7}, 16);
      chk(24'({ref_up, adc_pd, dac_pd}), 24'h133);
      wr({1'b0, ADDR_POWER_DOWN_REFERENCE_CONTROL, 11'h0F0}, 16);
      chk(24'({ref_up, adc_pd, dac_pd}), 24'h030);
      dac_ch = 8'hC3;
      @(posedge mclk) #10;
      chk(24'({ref_up, adc_pd, dac_pd}), 24'h0C0);
    end
  endtask
  // mid-run reset returns every register and output to zero
  task automatic t_rerst;
    begin
      nrst = 1'b0;
      @(posedge mclk) #10;
      chk(24'({pd_r, ts_r}), 24'h000000);
      chk(24'(od_r), 24'h000000);
      chk(pm, 24'h000000);
      nrst = 1'b1;
      repeat (3) @(posedge mclk);
      #10;
      chk(24'({ref_up, adc_pd, dac_pd}), 24'h000);
    end
  endtask
  task automatic t_pins;
    begin
      wr({1'b0, ADDR_OUT_SELECT, 11'h0F0}, 16);
      wr({1'b0, ADDR_OUTPUT_DRIVE_TYPE_CONFIG, 11'h0AA}, 16);
      chk(24'(od_r), 24'h0AA);
      chk(pm, {8'h00, 8'hA0, 8'h50});
      wr({1'b0, ADDR_PIN_TRISTATE_CONFIG, 11'h081}, 16);
      chk(pm, {8'h81, 8'h20, 8'h50});
    end
  endtask
  // bad msb, short frame and foreign address are all ignored
  task automatic t_refuse;
    begin
      wr({1'b1, ADDR_PIN_TRISTATE_CONFIG, 11'h0FF}, 16);
      wr({1'b0, ADDR_PIN_TRISTATE_CONFIG, 11'h0FF}, 15);
      wr({1'b0, 4'hA, 11'h0FF}, 16);
      chk(24'(ts_r), 24'h081);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    #10 nrst = 1'b1;
    repeat (3) @(posedge mclk);
    #10;
    t_reset;
    t_power;
    t_pins;
    t_refuse;
    t_rerst;
    print_verdict;
  end
  // about 350 cycles expected; cut off well beyond
  initial
  begin
    #2000000;
    error_cnt++;
    print_verdict;
  end
endmodule
